// File: rtl/occ_params.svh
// constants for the operator console control block
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH

// ==========================================================
// timing
`define OCC_CLK_MHZ 100
`define OCC_DEBOUNCE_US 5000

// ==========================================================
// register offsets and fields
`define OCC_OFS_CTRL 4'h0
`define OCC_OFS_STATUS 4'h4
`define OCC_RST_CTRL 32'h0000_0000
`define OCC_CTRL_INTEN_BIT 0
`define OCC_ST_STATE_LSB 0
`define OCC_ST_HALT_BIT 2
`define OCC_ST_PARITY_BIT 3
`define OCC_ST_INTEN_BIT 4
`define OCC_ST_STOP_BIT 5
`define OCC_ST_BREAK_LSB 8

// ==========================================================
// processor constants
`define OCC_OP_HALT 6'h00
`define OCC_OP_SKIP 6'h20
`define OCC_FILL_ADDR 14'h0002
`define OCC_FILL_INDEX 24'hFFFFFA

// ==========================================================
// display selector positions
`define OCC_SEL_INSTR 2'h0
`define OCC_SEL_ACC 2'h1
`define OCC_SEL_EXT 2'h2
`define OCC_SEL_INDEX 2'h3

`endif

// File: rtl/occ_pkg.sv
// types for the operator console control block
package occ_pkg;

  // processor run state seen from the console
  typedef enum logic [1:0] {
    OCC_RUN,
    OCC_IDLE,
    OCC_STEP
  } occ_run_t;

endpackage

// File: rtl/occ_debounce.sv
// synchroniser and sampling debouncer for panel switches
`timescale 1ns/100ps
`default_nettype none
module occ_debounce #(
  parameter int WIDTH = 8,
  parameter int SAMPLE_CYCLES = 500000
) (
  // clock and reset
  input wire logic sysClk,
  input wire logic rstN,
  // raw contacts
  input wire logic [WIDTH-1:0] rawIn,
  // cleaned levels and press pulses
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] press
);

  localparam int CW = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;

  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] samp_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] press_q;
  logic [CW-1:0] div_q;
  logic tick;

  // ==========================================================
  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // shared sample-rate divider
  assign tick = (div_q == CW'(SAMPLE_CYCLES - 1));

  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // accept a bit only when two samples in a row agree
  always_comb begin
    level_d = level_q;
    if (tick) begin
      level_d = (level_q & (samp_q ^ sync2_q)) | (sync2_q & ~(samp_q ^ sync2_q));
    end
  end

  // ==========================================================
  // sample store, level and one-cycle press pulse
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      samp_q <= '0;
      level_q <= '0;
      press_q <= '0;
    end else begin
      if (tick) begin
        samp_q <= sync2_q;
      end
      level_q <= level_d;
      press_q <= level_d & ~level_q;
    end
  end

  assign level = level_q;
  assign press = press_q;

endmodule
`default_nettype wire

// File: rtl/occ_console.sv
// operator console control: panel switches acting on the processor
//
// Operation
// - clear while idle zeroes every bit of the displayed register
// - an entry switch while idle sets its bit in the displayed register
// - toggle at run lets the processor run continuously
// - toggle at idle stops the processor after each instruction fetch
// - a step executes the held instruction once, then back to idle
// - one step per actuation; toggle must return to idle first
// - hold switch up keeps the program counter from advancing
// - parity action halt: a parity error forces idle
// - parity action continue: a parity error leaves the run state alone
// - interrupt switch at enable forces the interrupt system enabled
// - four breakpoint switches readable by the skip instruction, opcode 40
// - start resets the buffer, clears program counter, executes halt
// - fill reads one word into location 0002 and executes it
// - fill loads the index register with octal 77777772 at once
// - display shows instruction, accumulator, extension or index register
// - parity lamp lights on an error until the toggle is at idle
// - halt lamp on when halt executes, off on any other instruction
`timescale 1ns/100ps
`default_nettype none
`include "occ_params.svh"
module occ_console
  import occ_pkg::*;
#(
  parameter int DEB_CYCLES = `OCC_DEBOUNCE_US * `OCC_CLK_MHZ,
  parameter int WORD_W = 24
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // panel switches
  input wire logic [WORD_W-1:0] entrySw,
  input wire logic clearBtn,
  input wire logic runSw,
  input wire logic stepSw,
  input wire logic holdSw,
  input wire logic parityHaltSw,
  input wire logic intEnableSw,
  input wire logic [3:0] breakSw,
  input wire logic startBtn,
  input wire logic fillBtn,
  input wire logic [1:0] selSw,
  // processor status
  input wire logic execDone,
  input wire logic [5:0] execOpcode,
  input wire logic parityErr,
  input wire logic [WORD_W-1:0] instReg,
  input wire logic [WORD_W-1:0] accReg,
  input wire logic [WORD_W-1:0] extReg,
  input wire logic [WORD_W-1:0] idxReg,
  input wire logic skipQuery,
  input wire logic [1:0] skipSel,
  // processor control
  output logic execGo,
  output logic pcHold,
  output logic pcClear,
  output logic bufReset,
  output logic injectHalt,
  output logic [5:0] injectOpcode,
  output logic fillReq,
  output logic [13:0] fillAddr,
  output logic idxLoad,
  output logic [WORD_W-1:0] idxValue,
  output logic regWr,
  output logic [1:0] regWrSel,
  output logic [WORD_W-1:0] regWrData,
  output logic intEnabled,
  output logic skipAck,
  output logic skipNotSet,
  // panel indicators
  output logic [WORD_W-1:0] display,
  output logic haltLamp,
  output logic parityLamp,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRData
);

  localparam int NSW = WORD_W + 14;
  localparam int I_CLR = WORD_W;
  localparam int I_RUN = WORD_W + 1;
  localparam int I_STEP = WORD_W + 2;
  localparam int I_HOLD = WORD_W + 3;
  localparam int I_PAR = WORD_W + 4;
  localparam int I_INT = WORD_W + 5;
  localparam int I_START = WORD_W + 6;
  localparam int I_FILL = WORD_W + 7;
  localparam int I_BRK = WORD_W + 8;
  localparam int I_SEL = WORD_W + 12;

  logic [1:0] rstSync_q;
  logic rstN;
  logic [NSW-1:0] swLvl;
  logic [NSW-1:0] swPress;
  logic runLvl;
  logic stepLvl;
  logic toggleIdle;
  logic stepTake;
  logic parHalt;
  logic [1:0] selLvl;
  logic [WORD_W-1:0] entryP;
  logic [WORD_W-1:0] dispMux;
  occ_run_t state_q;
  occ_run_t state_d;
  logic stepArmed_q;
  logic stopLatch_q;
  logic regWr_q;
  logic [1:0] regWrSel_q;
  logic [WORD_W-1:0] regWrData_q;
  logic [WORD_W-1:0] display_q;
  logic pcHold_q;
  logic startPulse_q;
  logic fillPulse_q;
  logic haltLamp_q;
  logic parityLamp_q;
  logic intEn_q;
  logic skipAck_q;
  logic skipNotSet_q;
  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;

  // ==========================================================
  // reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  // ==========================================================
  // switch cleanup, one debouncer for the whole panel
  occ_debounce #(
    .WIDTH(NSW),
    .SAMPLE_CYCLES(DEB_CYCLES)
  ) u_debounce (
    .sysClk(sys_clk),
    .rstN(rstN),
    .rawIn({selSw, breakSw, fillBtn, startBtn, intEnableSw, parityHaltSw,
            holdSw, stepSw, runSw, clearBtn, entrySw}),
    .level(swLvl),
    .press(swPress)
  );

  assign runLvl = swLvl[I_RUN];
  assign stepLvl = swLvl[I_STEP];
  assign parHalt = swLvl[I_PAR];
  assign selLvl = swLvl[I_SEL +: 2];
  assign entryP = swPress[WORD_W-1:0];
  assign toggleIdle = !runLvl && !stepLvl;

  // status code of the run state for software
  function automatic logic [1:0] runCode(input occ_run_t s);
    case (s)
      OCC_RUN: runCode = 2'h1;
      OCC_STEP: runCode = 2'h2;
      default: runCode = 2'h0;
    endcase
  endfunction

  // ==========================================================
  // register chosen by the rotary selector
  always_comb begin
    case (selLvl)
      `OCC_SEL_INSTR: dispMux = instReg;
      `OCC_SEL_ACC: dispMux = accReg;
      `OCC_SEL_EXT: dispMux = extReg;
      default: dispMux = idxReg;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      display_q <= '0;
    end else begin
      display_q <= dispMux;
    end
  end

  // ==========================================================
  // step arming: must see the toggle back at idle before the next step
  assign stepTake = swPress[I_STEP] && stepArmed_q && (state_q == OCC_IDLE);

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      stepArmed_q <= 1'b0;
    end else if (toggleIdle) begin
      stepArmed_q <= 1'b1;
    end else if (stepTake) begin
      stepArmed_q <= 1'b0;
    end
  end

  // parity stop holds idle until the toggle returns to idle, set wins
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      stopLatch_q <= 1'b0;
    end else if (parityErr && parHalt) begin
      stopLatch_q <= 1'b1;
    end else if (toggleIdle) begin
      stopLatch_q <= 1'b0;
    end
  end

  // ==========================================================
  // run state machine
  always_comb begin
    state_d = state_q;
    if (swPress[I_START]) begin
      state_d = OCC_IDLE;
    end else if (parityErr && parHalt) begin
      state_d = OCC_IDLE;
    end else begin
      // with continue selected a parity error is not looked at here
      case (state_q)
        OCC_RUN: begin
          if (!runLvl) begin
            state_d = OCC_IDLE;
          end
        end
        OCC_IDLE: begin
          if (stepTake) begin
            state_d = OCC_STEP;
          end else if (runLvl && !stopLatch_q) begin
            state_d = OCC_RUN;
          end
        end
        OCC_STEP: begin
          if (execDone) begin
            state_d = OCC_IDLE;
          end
        end
        default: state_d = OCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= OCC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // processor may execute the fetched word only outside idle
  assign execGo = (state_q != OCC_IDLE);

  // ==========================================================
  // clear and entry switches write the displayed register when idle
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regWr_q <= 1'b0;
      regWrSel_q <= 2'h0;
      regWrData_q <= '0;
    end else begin
      regWr_q <= 1'b0;
      if (state_q == OCC_IDLE && (swPress[I_CLR] || (|entryP))) begin
        regWr_q <= 1'b1;
        regWrSel_q <= selLvl;
        if (swPress[I_CLR]) begin
          regWrData_q <= '0;
        end else begin
          regWrData_q <= dispMux | entryP;
        end
      end
    end
  end

  // ==========================================================
  // hold, start and fill actions
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pcHold_q <= 1'b0;
      startPulse_q <= 1'b0;
      fillPulse_q <= 1'b0;
    end else begin
      pcHold_q <= swLvl[I_HOLD];
      startPulse_q <= swPress[I_START];
      fillPulse_q <= swPress[I_FILL];
    end
  end

  assign injectOpcode = `OCC_OP_HALT;
  assign fillAddr = `OCC_FILL_ADDR;
  assign idxValue = `OCC_FILL_INDEX;

  // ==========================================================
  // indicators, a new error wins over the idle clear
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      haltLamp_q <= 1'b0;
      parityLamp_q <= 1'b0;
    end else begin
      if (execDone) begin
        haltLamp_q <= (execOpcode == `OCC_OP_HALT);
      end
      if (parityErr) begin
        parityLamp_q <= 1'b1;
      end else if (toggleIdle) begin
        parityLamp_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt enable and breakpoint skip test
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      intEn_q <= 1'b0;
      skipAck_q <= 1'b0;
      skipNotSet_q <= 1'b0;
    end else begin
      intEn_q <= swLvl[I_INT] || ctrl_q[`OCC_CTRL_INTEN_BIT];
      skipAck_q <= skipQuery && (execOpcode == `OCC_OP_SKIP);
      skipNotSet_q <= !swLvl[I_BRK + 32'(skipSel)];
    end
  end

  // ==========================================================
  // register port: control write, status read
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_q <= `OCC_RST_CTRL;
      rdata_q <= 32'h0;
    end else begin
      if (regWrEn && regAddr == `OCC_OFS_CTRL) begin
        ctrl_q <= {31'h0, regWData[`OCC_CTRL_INTEN_BIT]};
      end
      rdata_q <= 32'h0;
      if (regRdEn && regAddr == `OCC_OFS_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (regRdEn && regAddr == `OCC_OFS_STATUS) begin
        rdata_q[`OCC_ST_STATE_LSB +: 2] <= runCode(state_q);
        rdata_q[`OCC_ST_HALT_BIT] <= haltLamp_q;
        rdata_q[`OCC_ST_PARITY_BIT] <= parityLamp_q;
        rdata_q[`OCC_ST_INTEN_BIT] <= intEn_q;
        rdata_q[`OCC_ST_STOP_BIT] <= stopLatch_q;
        rdata_q[`OCC_ST_BREAK_LSB +: 4] <= swLvl[I_BRK +: 4];
      end
    end
  end

  // ==========================================================
  // outputs
  assign pcHold = pcHold_q;
  assign pcClear = startPulse_q;
  assign bufReset = startPulse_q;
  assign injectHalt = startPulse_q;
  assign fillReq = fillPulse_q;
  assign idxLoad = fillPulse_q;
  assign regWr = regWr_q;
  assign regWrSel = regWrSel_q;
  assign regWrData = regWrData_q;
  assign intEnabled = intEn_q;
  assign skipAck = skipAck_q;
  assign skipNotSet = skipNotSet_q;
  assign display = display_q;
  assign haltLamp = haltLamp_q;
  assign parityLamp = parityLamp_q;
  assign regRData = rdata_q;

  // ==========================================================
  // checks
  property p_clear_zero;
    @(posedge sys_clk) disable iff (!rstN)
    (swPress[I_CLR] && state_q == OCC_IDLE) |=> (regWr && regWrData == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero");

  property p_entry_set;
    @(posedge sys_clk) disable iff (!rstN)
    ((|entryP) && !swPress[I_CLR] && state_q == OCC_IDLE) |=>
      (regWr && regWrData == ($past(dispMux) | $past(entryP)));
  endproperty
  a_entry_set: assert property (p_entry_set) else $error("entry bit not set");

  property p_busy_ignore;
    @(posedge sys_clk) disable iff (!rstN)
    (state_q != OCC_IDLE) |=> !regWr;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("write while busy");

  property p_run_go;
    @(posedge sys_clk) disable iff (!rstN)
    (state_q == OCC_IDLE && runLvl && !stopLatch_q && !stepTake && !swPress[I_START]
      && !(parityErr && parHalt)) |=> execGo;
  endproperty
  a_run_go: assert property (p_run_go) else $error("run not entered");

  property p_idle_stop;
    @(posedge sys_clk) disable iff (!rstN)
    (!runLvl && state_q != OCC_STEP && !stepTake) |=> !execGo;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("executing in idle");

  property p_step_once;
    @(posedge sys_clk) disable iff (!rstN)
    (state_q == OCC_STEP && execDone && !swPress[I_START]) |=>
      !execGo ##1 (!execGo || $past(runLvl) || $past(stepTake));
  endproperty
  a_step_once: assert property (p_step_once) else $error("step did not return");

  property p_step_armed;
    @(posedge sys_clk) disable iff (!rstN)
    (state_q == OCC_IDLE && !stepArmed_q && !runLvl) |=> state_q != OCC_STEP;
  endproperty
  a_step_armed: assert property (p_step_armed) else $error("unarmed step");

  property p_hold;
    @(posedge sys_clk) disable iff (!rstN)
    swLvl[I_HOLD] |=> pcHold;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not passed");

  property p_par_halt;
    @(posedge sys_clk) disable iff (!rstN)
    (parityErr && parHalt) |=> (state_q == OCC_IDLE && parityLamp);
  endproperty
  a_par_halt: assert property (p_par_halt) else $error("parity did not halt");

  property p_int_force;
    @(posedge sys_clk) disable iff (!rstN)
    swLvl[I_INT] |=> intEnabled;
  endproperty
  a_int_force: assert property (p_int_force) else $error("interrupt not forced");

  property p_start;
    @(posedge sys_clk) disable iff (!rstN)
    swPress[I_START] |=> (pcClear && bufReset && injectHalt && injectOpcode == 6'h00);
  endproperty
  a_start: assert property (p_start) else $error("start actions missing");

  property p_fill;
    @(posedge sys_clk) disable iff (!rstN)
    swPress[I_FILL] |=> (fillReq && idxLoad && idxValue == 24'hFFFFFA && fillAddr == 14'h0002);
  endproperty
  a_fill: assert property (p_fill) else $error("fill actions missing");

  property p_halt_lamp;
    @(posedge sys_clk) disable iff (!rstN)
    execDone |=> (haltLamp == ($past(execOpcode) == 6'h00));
  endproperty
  a_halt_lamp: assert property (p_halt_lamp) else $error("halt lamp wrong");

  c_step: cover property (@(posedge sys_clk) disable iff (!rstN)
    state_q == OCC_IDLE ##1 state_q == OCC_STEP ##[1:20] state_q == OCC_IDLE);
  c_run: cover property (@(posedge sys_clk) disable iff (!rstN)
    state_q == OCC_IDLE ##1 state_q == OCC_RUN);
  c_parity: cover property (@(posedge sys_clk) disable iff (!rstN)
    state_q == OCC_RUN && parityErr && parHalt);
  c_fill: cover property (@(posedge sys_clk) disable iff (!rstN) fillReq);

endmodule
`default_nettype wire

// File: verification/occ_proc_model.sv
// behavioural processor model facing the console control block
`timescale 1ns/100ps
`default_nettype none
module occ_proc_model (
  // clock
  input wire logic sys_clk,
  // console control
  input wire logic execGo,
  input wire logic regWr,
  input wire logic [1:0] regWrSel,
  input wire logic [23:0] regWrData,
  input wire logic idxLoad,
  input wire logic [23:0] idxValue,
  // test controls
  input wire logic [5:0] nextOp,
  input wire logic slowMode,
  // processor status
  output logic execDone,
  output logic [5:0] execOpcode,
  output logic [23:0] instReg,
  output logic [23:0] accReg,
  output logic [23:0] extReg,
  output logic [23:0] idxReg
);
  // ==========================================================
  // registers seen by the display
  logic [23:0] regs [4] = '{24'h123456, 24'h00F0F0, 24'hA5A5A5, 24'h000000};
  logic [3:0] cnt = 4'h0;

  assign execOpcode = nextOp;
  assign instReg = regs[0];
  assign accReg = regs[1];
  assign extReg = regs[2];
  assign idxReg = regs[3];

  // executes only while allowed; prompt or slow latency
  always @(posedge sys_clk) begin
    execDone <= 1'h0;
    if (!execGo) begin
      cnt <= 4'h0;
    end else if (cnt == (slowMode ? 4'h6 : 4'h2)) begin
      execDone <= 1'h1;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // register writes from the panel and the fill load
  always @(posedge sys_clk) begin
    if (regWr) begin
      regs[regWrSel] <= regWrData;
    end
    if (idxLoad) begin
      regs[3] <= idxValue;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the operator console control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ==========================================================
  // signals
  logic sys_clk = '0;
  logic rst_n = '0;
  logic [23:0] entrySw = '0;
  logic clearBtn = '0, runSw = '0, stepSw = '0, holdSw = '0, parityHaltSw = '0;
  logic intEnableSw = '0, startBtn = '0, fillBtn = '0, parityErr = '0, skipQuery = '0;
  logic regWrEn = '0, regRdEn = '0, slowMode = '0;
  logic [3:0] breakSw = '0, regAddr = '0, bs;
  logic [1:0] selSw = '0, skipSel = '0, regWrSel, wrSel;
  logic [5:0] execOpcode, injectOpcode, nextOp = '0;
  logic [31:0] regWData = '0, regRData, rdv;
  logic [23:0] instReg, accReg, extReg, idxReg, idxValue, regWrData, display, wrData, expW;
  logic execDone, execGo, pcHold, pcClear, bufReset, injectHalt, fillReq, idxLoad, regWr;
  logic intEnabled, skipAck, skipNotSet, haltLamp, parityLamp, lastNot;
  logic [13:0] fillAddr;
  int mismatches = 0, n_checks = 0, cyc = 0, nWr = 0, nDone = 0, nSkip = 0;
  int nStart = 0, nFill = 0, nSplit = 0, n0, nb;

  occ_console #(.DEB_CYCLES(4)) occ_console_inst (.*);
  occ_proc_model occ_proc_model_inst (.*);

  always #5 sys_clk = ~sys_clk;

  // ==========================================================
  // monitor of pulses and timeout
  always @(posedge sys_clk) begin
    if (regWr) begin
      nWr++;
      wrSel = regWrSel;
      wrData = regWrData;
    end
    if (execDone) nDone++;
    if (skipAck) begin
      nSkip++;
      lastNot = skipNotSet;
    end
    if (pcClear | bufReset | injectHalt) begin
      nStart++;
      if (!(pcClear & bufReset & injectHalt)) nSplit++;
    end
    if (fillReq | idxLoad) begin
      nFill++;
      if (!(fillReq & idxLoad)) nSplit++;
    end
    if (++cyc == 20000) begin
      mismatches++;
      complete_run;
    end
  end

  // ==========================================================
  // tasks
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task waitc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // long enough for sync plus two debounce ticks
  task settle;
    waitc(30);
  endtask

  task press(input int k, input int b);
    @(posedge sys_clk);
    case (k)
      0: clearBtn <= 1'h1;
      1: startBtn <= 1'h1;
      2: fillBtn <= 1'h1;
      default: entrySw <= 24'h000001 << b;
    endcase
    settle;
    @(posedge sys_clk);
    {clearBtn, startBtn, fillBtn} <= 3'h0;
    entrySw <= '0;
    settle;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrEn <= 1'h1;
    regAddr <= a;
    regWData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'h0;
  endtask

  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    regRdEn <= 1'h1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'h0;
    #1;
    rdv = regRData;
  endtask

  task pulse_parity;
    @(posedge sys_clk);
    parityErr <= 1'h1;
    @(posedge sys_clk);
    parityErr <= 1'h0;
    waitc(4);
  endtask

  task done_test(input string s);
    $display("test %s finished", s);
  endtask

  // expected register after one entry switch press
  function automatic logic [23:0] entry_exp(input logic [23:0] cur, input int b);
    return cur | (24'h000001 << b);
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(73));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    waitc(5);
    rd(4'h4);
    chk("status idle", 32'h0, rdv & 32'h3);
    rd(4'h8);
    chk("unmapped read", 32'h0, rdv);
    wr(4'h0, 32'h1);
    waitc(3);
    chk("program int enable", 1, intEnabled);
    rd(4'h0);
    chk("ctrl readback", 32'h1, rdv);
    wr(4'h0, 32'h0);
    waitc(3);
    chk("program int disable", 0, intEnabled);
    intEnableSw <= 1'h1;
    settle;
    chk("panel int enable", 1, intEnabled);
    intEnableSw <= 1'h0;
    done_test("interrupt enable");
    for (int s = 0; s < 4; s++) begin
      selSw <= s[1:0];
      settle;
      chk("display", occ_proc_model_inst.regs[s], display);
      nb = $urandom % 24;
      expW = entry_exp(occ_proc_model_inst.regs[s], nb);
      n0 = nWr;
      press(3, nb);
      chk("entry write count", 1, nWr - n0);
      chk("entry select", s, wrSel);
      chk("entry data", expW, wrData);
      chk("display entry", expW, display);
      press(0, 0);
      chk("clear data", 0, wrData);
    end
    done_test("clear and entry");
    slowMode <= 1'($urandom);
    runSw <= 1'h1;
    settle;
    chk("run go", 1, execGo);
    rd(4'h4);
    chk("status run", 32'h1, rdv & 32'h3);
    n0 = nDone;
    waitc(40);
    chk("running", 1, nDone - n0 > 3);
    chk("halt lamp on", 1, haltLamp);
    nextOp <= 6'h11;
    waitc(20);
    chk("halt lamp off", 0, haltLamp);
    holdSw <= 1'h1;
    settle;
    chk("pc hold", 1, pcHold);
    holdSw <= 1'h0;
    settle;
    chk("pc hold release", 0, pcHold);
    n0 = nWr;
    press(0, 0);
    press(3, 5);
    chk("ignored presses", 0, nWr - n0);
    runSw <= 1'h0;
    settle;
    chk("idle stop", 0, execGo);
    done_test("run");
    slowMode <= 1'h1;
    for (int i = 1; i < 3; i++) begin
      n0 = nDone;
      @(posedge sys_clk);
      stepSw <= 1'h1;
      waitc(60);
      chk("one step", 1, nDone - n0);
      chk("back to idle", 0, execGo);
      stepSw <= 1'h0;
      settle;
    end
    done_test("step");
    parityHaltSw <= 1'h1;
    runSw <= 1'h1;
    settle;
    pulse_parity;
    chk("parity halt", 0, execGo);
    chk("parity lamp on", 1, parityLamp);
    runSw <= 1'h0;
    settle;
    chk("parity lamp off", 0, parityLamp);
    parityHaltSw <= 1'h0;
    runSw <= 1'h1;
    settle;
    pulse_parity;
    chk("parity continue", 1, execGo);
    runSw <= 1'h0;
    settle;
    done_test("parity");
    bs = 4'($urandom);
    breakSw <= bs;
    nextOp <= 6'h20;
    settle;
    rd(4'h4);
    chk("status breakpoints", {20'h0, bs, 8'h0}, rdv & 32'hF00);
    for (int i = 0; i < 4; i++) begin
      n0 = nSkip;
      @(posedge sys_clk);
      skipQuery <= 1'h1;
      skipSel <= i[1:0];
      @(posedge sys_clk);
      skipQuery <= 1'h0;
      waitc(3);
      chk("skip ack", 1, nSkip - n0);
      chk("skip not set", !bs[i], lastNot);
    end
    done_test("breakpoints");
    press(1, 0);
    chk("start pulses", 1, nStart);
    chk("start halt opcode", 6'h00, injectOpcode);
    rd(4'h4);
    chk("start idle", 32'h0, rdv & 32'h3);
    runSw <= 1'h1;
    settle;
    press(2, 0);
    chk("fill pulses", 1, nFill);
    chk("fill address", 14'h0002, fillAddr);
    chk("fill index", 24'hFFFFFA, occ_proc_model_inst.regs[3]);
    chk("split pulses", 0, nSplit);
    runSw <= 1'h0;
    settle;
    done_test("start and fill");
    complete_run;
  end
endmodule
`default_nettype wire
